//--- dv/reservation_snoop_filter_test.sv
// bench: processor end and l2 end joined over the bus interface.
// assumes: rtl and rsf_cfg.svh on the include path; ce tied high.
`timescale 1ns/10ps
`include "rsf_cfg.svh"

module reservation_snoop_filter_test;
	import rsf_pkg::*;
	// ==========================================================
	// stimulus, outputs, model
	logic        clk_in, reset_n_in, mode, lr_req, lr_cach, lr_hit, sc_req, sc_wb, sc_en;
	logic        sys_v, busy, resv_v, sc_ok, cancel, system_shared_response, retry, fwd_v, held_m, fv_m;
	rsf_addr_t   lr_addr, sc_addr, sys_a, ra_m, fa_m, a;
	rsf_tt_t     sys_tt, fwd_tt, tt_m;
	logic        upper, down, filt_v;
	rsf_addr_t   resv_addr, fwd_addr, filt_addr, la_m;
	// snoop codes that must leave a reservation alone, and those that cancel
	rsf_tt_t sys_tt_list[4] = '{`RSF_TT_CLEAN, `RSF_TT_FLUSH, `RSF_TT_SET_RESV, `RSF_TT_CLR_RESV};
	rsf_tt_t cancel_list[5] = '{`RSF_TT_RFO, `RSF_TT_RFO_AT, `RSF_TT_KILL, `RSF_TT_WR_FLUSH,
		`RSF_TT_WR_FLUSH_AT};
	logic [11:0] got, want;
	logic [11:0] notes[$];
	integer      seed;
	int          failures, checks_done;

	rsf_bus_if rsf_bus_if_i ();
	rsf_proc_end rsf_proc_end_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(1'b1),
		.bus(rsf_bus_if_i), .lr_req_in(lr_req), .lr_addr_in(lr_addr),
		.lr_cacheable_in(lr_cach), .lr_cache_hit_in(lr_hit), .sc_req_in(sc_req),
		.sc_addr_in(sc_addr), .sc_write_back_in(sc_wb), .sc_clear_en_in(sc_en),
		.busy_out(busy), .resv_valid_out(resv_v), .resv_addr_out(resv_addr),
		.sc_success_out(sc_ok), .resv_cancel_out(cancel));
	rsf_l2_end rsf_l2_end_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(1'b1),
		.improved_mode_in(mode), .bus(rsf_bus_if_i), .sys_snp_valid_in(sys_v),
		.sys_snp_addr_in(sys_a), .sys_snp_tt_in(sys_tt), .upper_resv_in(upper),
		.system_shared_response_out(system_shared_response), .sys_retry_out(retry),
		.reservation_down_out(down), .fwd_valid_out(fwd_v), .fwd_addr_out(fwd_addr),
		.fwd_tt_out(fwd_tt), .filt_valid_out(filt_v), .filt_addr_out(filt_addr));
	rsf_chk rsf_chk_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.p_ts_in(rsf_bus_if_i.p_ts), .p_addr_in(rsf_bus_if_i.p_addr),
		.p_tt_in(rsf_bus_if_i.p_tt),
		.address_acknowledge_in(rsf_bus_if_i.address_acknowledge),
		.snp_valid_in(rsf_bus_if_i.snp_valid), .snp_addr_in(rsf_bus_if_i.snp_addr),
		.snp_tt_in(rsf_bus_if_i.snp_tt),
		.shared_response_in(rsf_bus_if_i.shared_response),
		.reservation_held_in(rsf_bus_if_i.reservation_held));

	// ==========================================================
	// tasks
	task automatic end_of_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	// pulses sc,cancel,snoop,retry,shared,fwd then held level and fwd code
	task automatic note(input logic [6:0] p);
		notes.push_back({p, tt_m});
	endtask
	task automatic settle();
		int n;
		n = 0;
		repeat (3) @(negedge clk_in);
		while (busy !== 1'b0 && n < 20) begin
			@(negedge clk_in);
			n++;
		end
		if (n == 20) begin
			failures++;
			end_of_test();
		end
		check("held level", 32'(held_m), 32'(resv_v));
		check("merged down", 32'(held_m | upper), 32'(down));
		check("filter valid", 32'(fv_m), 32'(filt_v));
		check("tenure addr", la_m, fwd_addr);
		if (held_m) check("resv addr", ra_m, resv_addr);
		if (fv_m) check("filter addr", fa_m, filt_addr);
	endtask
	task automatic do_lr(input rsf_addr_t ad, input logic c, input logic h);
		@(negedge clk_in);
		lr_req = 1'b1;
		lr_addr = ad;
		lr_cach = c;
		lr_hit = h;
		@(negedge clk_in);
		// second request lands while busy and must vanish
		lr_addr = ~ad;
		tt_m = (c && h) ? `RSF_TT_SET_RESV : `RSF_TT_READ_AT;
		note({6'h01, (c && h) || held_m});
		@(negedge clk_in);
		lr_req = 1'b0;
		held_m = 1'b1;
		ra_m = ad;
		fv_m = 1'b1;
		fa_m = ad;
		la_m = ad;
		settle();
	endtask
	task automatic do_sc(input rsf_addr_t ad, input logic wb, input logic en);
		@(negedge clk_in);
		sc_req = 1'b1;
		sc_addr = ad;
		sc_wb = wb;
		sc_en = en;
		if (held_m && ad[31:5] == ra_m[31:5]) note(7'h40);
		if (wb && en) begin
			tt_m = `RSF_TT_CLR_RESV;
			note(7'h02);
			fv_m = 1'b0;
			la_m = ad;
		end
		@(negedge clk_in);
		sc_req = 1'b0;
		held_m = 1'b0;
		settle();
	endtask
	task automatic do_sys(input rsf_tt_t t, input rsf_addr_t ad);
		logic fm, pm, fw, sh;
		pm = held_m && ad[31:5] == ra_m[31:5];
		fm = fv_m && ad[31:5] == fa_m[31:5];
		fw = (t inside {`RSF_TT_RFO, `RSF_TT_RFO_AT, `RSF_TT_KILL, `RSF_TT_WR_FLUSH,
			`RSF_TT_WR_FLUSH_AT}) && (mode ? fm : held_m);
		sh = (t inside {`RSF_TT_READ, `RSF_TT_READ_AT}) && (mode ? fm : held_m);
		@(negedge clk_in);
		sys_v = 1'b1;
		sys_tt = t;
		sys_a = ad;
		upper = 1'($random(seed));
		if (fw || sh) note({2'b00, fw, fw, sh, 1'b0, held_m});
		if (fw && pm) note(7'h20);
		@(negedge clk_in);
		sys_v = 1'b0;
		held_m = held_m && !(fw && pm);
		if (mode && fw) fv_m = 1'b0;
		settle();
	endtask

	// ==========================================================
	// clock and result watcher
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	always @(negedge clk_in) begin
		got = {sc_ok, cancel, rsf_bus_if_i.snp_valid, retry, system_shared_response, fwd_v, resv_v, fwd_tt};
		if (reset_n_in === 1'b1 && got[11:6] !== 6'h00) begin
			want = (notes.size() > 0) ? notes.pop_front() : 12'hxxx;
			check("result", 32'(want), 32'(got));
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		seed = 32'h6af2;
		{mode, reset_n_in, lr_req, lr_cach, lr_hit, sc_req, sc_wb, sc_en, sys_v} = '0;
		{lr_addr, sc_addr, sys_a, ra_m, fa_m, la_m} = '0;
		{sys_tt, tt_m, held_m, fv_m, upper} = '0;
		repeat (8) @(negedge clk_in);
		reset_n_in = 1'b1;
		do_sc($random(seed), 1'b1, 1'b0);
		a = $random(seed);
		do_lr(a, 1'b1, 1'b0);
		do_sys(`RSF_TT_READ, {a[31:5], 5'($random(seed))});
		foreach (sys_tt_list[i]) do_sys(sys_tt_list[i], a);
		do_sys(`RSF_TT_RFO, a ^ 32'h0000_0100);
		do_sys(`RSF_TT_KILL, a);
		do_sys(`RSF_TT_RFO, a);
		$display("test minimal scheme done");
		mode = 1'b1;
		a = $random(seed);
		do_lr(a, 1'b1, 1'b1);
		do_sys(`RSF_TT_READ, a ^ 32'h0000_0040);
		do_sys(`RSF_TT_READ_AT, a);
		do_sys(`RSF_TT_RFO, a ^ 32'h0000_0080);
		foreach (cancel_list[i]) begin
			do_lr(a, 1'b1, 1'b1);
			do_sys(cancel_list[i], a);
		end
		do_sys(`RSF_TT_RFO, a);
		do_lr(a, 1'b0, 1'b1);
		do_sc(a, 1'b1, 1'b1);
		do_sys(`RSF_TT_RFO, a);
		do_lr(a, 1'b1, 1'b1);
		do_sc(a, 1'b1, 1'b0);
		do_sys(`RSF_TT_RFO, a);
		$display("test improved scheme done");
		repeat (5) @(negedge clk_in);
		check("leftover notes", 32'h0000_0000, 32'(notes.size()));
		end_of_test();
	end
endmodule

//--- dv/rsf_chk.sv
// assertions on the processor bus joining the two filter ends.
// assumes: instantiated beside the interface; ce held high.
`timescale 1ns/10ps
`include "rsf_cfg.svh"

module rsf_chk
	import rsf_pkg::*;
(
	// clock and reset
	input wire logic      clk_in,
	input wire logic      reset_n_in,
	// processor tenure
	input wire logic      p_ts_in,
	input wire rsf_addr_t p_addr_in,
	input wire rsf_tt_t   p_tt_in,
	input wire logic      address_acknowledge_in,
	// snoops and status
	input wire logic      snp_valid_in,
	input wire rsf_addr_t snp_addr_in,
	input wire rsf_tt_t   snp_tt_in,
	input wire logic      shared_response_in,
	input wire logic      reservation_held_in
);
	// ==========================================================
	// last announced reservation address
	rsf_addr_t ra_q;
	rsf_addr_t ra_d;
	logic      blk_eq;
	logic      same;
	logic      kill;
	logic      rd;
	always_comb begin
		ra_d = ra_q;
		if (!reset_n_in) begin
			ra_d = `RSF_ADDR_RST;
		end else if (p_ts_in && p_tt_in inside {`RSF_TT_SET_RESV, `RSF_TT_READ_AT}) begin
			ra_d = p_addr_in;
		end
	end
	always_ff @(posedge clk_in) begin
		ra_q <= ra_d;
	end
	assign blk_eq = snp_addr_in[`RSF_ADDR_W-1:`RSF_BLK_LSB] ==
		ra_q[`RSF_ADDR_W-1:`RSF_BLK_LSB];
	assign same   = snp_valid_in && reservation_held_in && blk_eq;
	assign kill   = snp_tt_in inside {`RSF_TT_RFO, `RSF_TT_RFO_AT, `RSF_TT_KILL};
	assign rd     = snp_tt_in inside {`RSF_TT_READ, `RSF_TT_READ_AT};
	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	chk_ack_follows: assert property (p_ts_in |=> address_acknowledge_in)
		else $error("no acknowledge after tenure");
	chk_held_by_ack: assert property (p_ts_in && p_tt_in == `RSF_TT_READ_AT
		##1 address_acknowledge_in |=> reservation_held_in)
		else $error("held late after read-atomic");
	chk_held_rise: assert property ($rose(reservation_held_in)
		|-> p_ts_in || $past(address_acknowledge_in))
		else $error("held rose without cause");
	chk_set_held: assert property (p_ts_in && p_tt_in == `RSF_TT_SET_RESV
		|-> reservation_held_in)
		else $error("set op without held");
	chk_clr_dropped: assert property (p_ts_in && p_tt_in == `RSF_TT_CLR_RESV
		|-> !reservation_held_in)
		else $error("clear op while held");
	chk_tt_legal: assert property (p_ts_in
		|-> p_tt_in inside {`RSF_TT_SET_RESV, `RSF_TT_CLR_RESV, `RSF_TT_READ_AT})
		else $error("unexpected transfer type");
	chk_one_tenure: assert property (p_ts_in |=> !p_ts_in [*2])
		else $error("tenures too close");
	chk_cancel_match: assert property (same && kill |=> !reservation_held_in)
		else $error("matching cancel kept reservation");
	chk_keep_other: assert property (snp_valid_in && reservation_held_in && !blk_eq
		|=> reservation_held_in)
		else $error("unmatched snoop dropped reservation");
	chk_shared_read: assert property (same && rd |=> shared_response_in)
		else $error("matching read not answered shared");
	chk_shared_cause: assert property (!snp_valid_in |=> !shared_response_in)
		else $error("shared without a snoop");
	cover property (p_ts_in && p_tt_in == `RSF_TT_READ_AT);
	cover property (same && kill);
	cover property (p_ts_in && p_tt_in == `RSF_TT_CLR_RESV);
	cover property (snp_valid_in && reservation_held_in && !blk_eq);
endmodule

//--- rtl/rsf_bus_if.sv
// processor bus between the processor's reservation end and the l2 filter.
// assumes: both ends run on the same clock; no tristate on these wires.
`timescale 1ns/10ps

interface rsf_bus_if;
	import rsf_pkg::*;
	// ==========================================================
	// processor address tenure
	logic      p_ts;
	rsf_addr_t p_addr;
	rsf_tt_t   p_tt;
	logic      address_acknowledge;
	// ==========================================================
	// snoops passed up to the processor, shared and held passed back down
	logic      snp_valid;
	rsf_addr_t snp_addr;
	rsf_tt_t   snp_tt;
	logic      shared_response;
	logic      reservation_held;

	modport proc_end (
		output p_ts, p_addr, p_tt, shared_response, reservation_held,
		input  address_acknowledge, snp_valid, snp_addr, snp_tt
	);
	modport l2_end (
		input  p_ts, p_addr, p_tt, shared_response, reservation_held,
		output address_acknowledge, snp_valid, snp_addr, snp_tt
	);
endinterface

//--- rtl/rsf_cfg.svh
// constants for the reservation snoop filter: transfer-type codes,
// address compare width and reset values.
// assumes: included by bare name from the package and the design files.
`ifndef RSF_CFG_SVH
`define RSF_CFG_SVH

// ==========================================================
// widths
`define RSF_ADDR_W      32
`define RSF_TT_W        5
// reservation granule: compare down to the cache block
`define RSF_BLK_LSB     5

// ==========================================================
// transfer-type codes
`define RSF_TT_CLEAN        5'h00
`define RSF_TT_SET_RESV     5'h01
`define RSF_TT_CLR_RESV     5'h02
`define RSF_TT_FLUSH        5'h04
`define RSF_TT_WR_FLUSH     5'h06
`define RSF_TT_READ         5'h0a
`define RSF_TT_KILL         5'h0c
`define RSF_TT_RFO          5'h0e
`define RSF_TT_WR_FLUSH_AT  5'h16
`define RSF_TT_READ_AT      5'h1a
`define RSF_TT_RFO_AT       5'h1e

// ==========================================================
// reset values
`define RSF_ADDR_RST    32'h0000_0000
`define RSF_TT_RST      5'h00

`endif

//--- rtl/rsf_l2_end.sv
// l2 side of the reservation filter: acknowledges processor tenures, passes
// them down, filters system snoops up, answers shared and retry.
// assumes: system snoop inputs are on clk_in; one snoop per cycle at most.
`timescale 1ns/10ps
`include "rsf_cfg.svh"

module rsf_l2_end
	import rsf_pkg::*;
(
	// clock, reset, enable
	input  wire logic      clk_in,
	input  wire logic      reset_n_in,
	input  wire logic      ce_in,
	// scheme select
	input  wire logic      improved_mode_in,
	// processor bus
	rsf_bus_if.l2_end      bus,
	// system bus side
	input  wire logic      sys_snp_valid_in,
	input  wire rsf_addr_t sys_snp_addr_in,
	input  wire rsf_tt_t   sys_snp_tt_in,
	input  wire logic      upper_resv_in,
	output logic           system_shared_response_out,
	output logic           sys_retry_out,
	output logic           reservation_down_out,
	output logic           fwd_valid_out,
	output rsf_addr_t      fwd_addr_out,
	output rsf_tt_t        fwd_tt_out,
	output logic           filt_valid_out,
	output rsf_addr_t      filt_addr_out
);
	// ==========================================================
	// decode
	logic is_cancel;
	logic is_read;
	logic match;
	logic fwd;
	logic hit_read;
	assign is_cancel = (sys_snp_tt_in == `RSF_TT_RFO) || (sys_snp_tt_in == `RSF_TT_RFO_AT) ||
		(sys_snp_tt_in == `RSF_TT_KILL) || (sys_snp_tt_in == `RSF_TT_WR_FLUSH) ||
		(sys_snp_tt_in == `RSF_TT_WR_FLUSH_AT);
	assign is_read = (sys_snp_tt_in == `RSF_TT_READ) || (sys_snp_tt_in == `RSF_TT_READ_AT);
	assign match = filt_valid_out &&
		(sys_snp_addr_in[`RSF_ADDR_W-1:`RSF_BLK_LSB] == filt_addr_out[`RSF_ADDR_W-1:`RSF_BLK_LSB]);

	always_comb begin
		if (improved_mode_in) begin
			fwd      = sys_snp_valid_in && is_cancel && match;
			hit_read = sys_snp_valid_in && is_read && match;
		end else begin
			fwd      = sys_snp_valid_in && is_cancel && bus.reservation_held;
			hit_read = sys_snp_valid_in && is_read && bus.reservation_held;
		end
	end

	// merged indication, no per-address state needed for it
	assign reservation_down_out = bus.reservation_held | upper_resv_in;

	// ==========================================================
	// state
	logic      ack_d, ack_q;
	logic      fv_d, fv_q;
	rsf_addr_t fa_d, fa_q;
	rsf_tt_t   ft_d, ft_q;
	logic      sv_d, sv_q;
	rsf_addr_t sa_d, sa_q;
	rsf_tt_t   st_d, st_q;
	logic      shd_d, shd_q;
	logic      rty_d, rty_q;
	logic      flv_d, flv_q;
	rsf_addr_t fla_d, fla_q;

	always_comb begin
		ack_d = bus.p_ts;
		fv_d  = bus.p_ts;
		fa_d  = bus.p_ts ? bus.p_addr : fa_q;
		ft_d  = bus.p_ts ? bus.p_tt : ft_q;
		sv_d  = fwd;
		sa_d  = fwd ? sys_snp_addr_in : sa_q;
		st_d  = fwd ? sys_snp_tt_in : st_q;
		// extra shared and retry traffic is the price of the minimal scheme
		shd_d = hit_read;
		rty_d = fwd;
		flv_d = flv_q;
		fla_d = fla_q;
		if (fwd && improved_mode_in)
			flv_d = 1'b0;
		if (bus.p_ts && (bus.p_tt == `RSF_TT_CLR_RESV))
			flv_d = 1'b0;
		if (bus.p_ts && ((bus.p_tt == `RSF_TT_SET_RESV) || (bus.p_tt == `RSF_TT_READ_AT))) begin
			flv_d = 1'b1;
			fla_d = bus.p_addr;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			ack_q <= 1'b0;
			fv_q  <= 1'b0;
			fa_q  <= `RSF_ADDR_RST;
			ft_q  <= `RSF_TT_RST;
			sv_q  <= 1'b0;
			sa_q  <= `RSF_ADDR_RST;
			st_q  <= `RSF_TT_RST;
			shd_q <= 1'b0;
			rty_q <= 1'b0;
			flv_q <= 1'b0;
			fla_q <= `RSF_ADDR_RST;
		end else if (ce_in) begin
			ack_q <= ack_d;
			fv_q  <= fv_d;
			fa_q  <= fa_d;
			ft_q  <= ft_d;
			sv_q  <= sv_d;
			sa_q  <= sa_d;
			st_q  <= st_d;
			shd_q <= shd_d;
			rty_q <= rty_d;
			flv_q <= flv_d;
			fla_q <= fla_d;
		end
	end

	assign bus.address_acknowledge    = ack_q;
	assign bus.snp_valid              = sv_q;
	assign bus.snp_addr               = sa_q;
	assign bus.snp_tt                 = st_q;
	assign system_shared_response_out = shd_q | (bus.shared_response & ~improved_mode_in);
	assign sys_retry_out              = rty_q;
	assign fwd_valid_out              = fv_q;
	assign fwd_addr_out               = fa_q;
	assign fwd_tt_out                 = ft_q;
	assign filt_valid_out             = flv_q;
	assign filt_addr_out              = fla_q;
endmodule

//--- rtl/rsf_pkg.sv
// types shared by both ends of the reservation snoop filter.
// assumes: rsf_cfg.svh is on the include path.
`include "rsf_cfg.svh"

package rsf_pkg;
	typedef logic [`RSF_ADDR_W-1:0] rsf_addr_t;
	typedef logic [`RSF_TT_W-1:0]   rsf_tt_t;

	typedef enum logic [1:0] {
		RSF_IDLE  = 2'b00,
		RSF_ISSUE = 2'b01,
		RSF_WAIT  = 2'b10
	} rsf_state_t;

	typedef enum logic [1:0] {
		RSF_OP_READ_AT = 2'b00,
		RSF_OP_SET     = 2'b01,
		RSF_OP_CLR     = 2'b10
	} rsf_op_t;
endpackage

//--- rtl/rsf_proc_end.sv
// processor end of the reservation filter: holds the load-reserve
// reservation, announces it on the bus, snoops for cancel and shared.
// assumes: the l2 end acknowledges every tenure; core requests are single
// cycle and only taken while busy_out is low.
//
// Behaviour
// - clean and flush snoops keep reservation
// - l2 may drop snoops while not held
// - l2 forwards influencing snoops while held
// - l2 answers reads shared in minimal scheme
// - minimal l2 keeps only merged indication; l2 end still keeps its filter address register in both schemes
// - held asserts cycle after acknowledge, or with the set op tenure (cycle after the load-reserve is taken)
// - improved l2 keeps address register and comparator
// - improved l2 forwards only modifying cycles
// - retries and shared only on matching address; minimal scheme: on any address while held
// - miss or noncacheable: read-atomic carries address
// - cache hit load-reserve: address-only set op
// - store-conditional may send clear op, optional
// - set code 00001, clear code 00010
// - new codes look harmless like clean/flush
// - one extra cycle per cacheable hit only
// - one extra cycle per write-back store-conditional
// - matching rfo, atomic rfo, kill cancel reservation
// - held: answer matching reads with shared
`timescale 1ns/10ps
`include "rsf_cfg.svh"

module rsf_proc_end
	import rsf_pkg::*;
(
	// clock, reset, enable
	input  wire logic      clk_in,
	input  wire logic      reset_n_in,
	input  wire logic      ce_in,
	// processor bus
	rsf_bus_if.proc_end    bus,
	// load-reserve request from the core
	input  wire logic      lr_req_in,
	input  wire rsf_addr_t lr_addr_in,
	input  wire logic      lr_cacheable_in,
	input  wire logic      lr_cache_hit_in,
	// store-conditional request from the core
	input  wire logic      sc_req_in,
	input  wire rsf_addr_t sc_addr_in,
	input  wire logic      sc_write_back_in,
	input  wire logic      sc_clear_en_in,
	// status to the core
	output logic           busy_out,
	output logic           resv_valid_out,
	output rsf_addr_t      resv_addr_out,
	output logic           sc_success_out,
	output logic           resv_cancel_out
);
	// ==========================================================
	// snoop decode
	logic snp_match;
	logic snp_cancel;
	logic snp_read;

	assign snp_match = bus.snp_valid && resv_valid_out &&
		(bus.snp_addr[`RSF_ADDR_W-1:`RSF_BLK_LSB] ==
		 resv_addr_out[`RSF_ADDR_W-1:`RSF_BLK_LSB]);

	// clean, flush and the two reservation codes fall outside this set,
	// so they never cancel
	always_comb begin
		case (bus.snp_tt)
			`RSF_TT_RFO,
			`RSF_TT_RFO_AT,
			`RSF_TT_KILL,
			`RSF_TT_WR_FLUSH,
			`RSF_TT_WR_FLUSH_AT: snp_cancel = snp_match;
			default:             snp_cancel = 1'b0;
		endcase
	end

	assign snp_read = snp_match &&
		((bus.snp_tt == `RSF_TT_READ) || (bus.snp_tt == `RSF_TT_READ_AT));

	// ==========================================================
	// request sequencer
	rsf_state_t state_d, state_q;
	rsf_op_t    op_d, op_q;
	rsf_addr_t  addr_d, addr_q;
	logic       lr_take;
	logic       sc_take;

	assign busy_out = (state_q != RSF_IDLE);
	assign lr_take  = lr_req_in && !busy_out;
	// load-reserve wins if both arrive together
	assign sc_take  = sc_req_in && !busy_out && !lr_req_in;

	always_comb begin
		state_d = state_q;
		op_d    = op_q;
		addr_d  = addr_q;
		case (state_q)
			RSF_IDLE: begin
				if (lr_take) begin
					state_d = RSF_ISSUE;
					addr_d  = lr_addr_in;
					if (lr_cacheable_in && lr_cache_hit_in)
						op_d = RSF_OP_SET;
					else
						op_d = RSF_OP_READ_AT;
				end else if (sc_take && sc_write_back_in && sc_clear_en_in) begin
					state_d = RSF_ISSUE;
					addr_d  = sc_addr_in;
					op_d    = RSF_OP_CLR;
				end
			end
			RSF_ISSUE: begin
				state_d = RSF_WAIT;
			end
			RSF_WAIT: begin
				if (bus.address_acknowledge)
					state_d = RSF_IDLE;
			end
			default: begin
				state_d = RSF_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			state_q <= RSF_IDLE;
			op_q    <= RSF_OP_READ_AT;
			addr_q  <= `RSF_ADDR_RST;
		end else if (ce_in) begin
			state_q <= state_d;
			op_q    <= op_d;
			addr_q  <= addr_d;
		end
	end

	// one-cycle address tenure
	always_comb begin
		bus.p_ts   = (state_q == RSF_ISSUE);
		bus.p_addr = addr_q;
		case (op_q)
			RSF_OP_SET:     bus.p_tt = `RSF_TT_SET_RESV;
			RSF_OP_CLR:     bus.p_tt = `RSF_TT_CLR_RESV;
			RSF_OP_READ_AT: bus.p_tt = `RSF_TT_READ_AT;
			default:        bus.p_tt = `RSF_TT_READ_AT;
		endcase
	end

	// ==========================================================
	// reservation state
	logic      rv_d, rv_q;
	rsf_addr_t ra_d, ra_q;
	logic      ok_d, ok_q;
	logic      cx_d, cx_q;
	logic      shd_d, shd_q;
	logic      ack_ra;

	assign ack_ra = (state_q == RSF_WAIT) && bus.address_acknowledge &&
		(op_q == RSF_OP_READ_AT);

	always_comb begin
		rv_d  = rv_q;
		ra_d  = ra_q;
		ok_d  = 1'b0;
		cx_d  = snp_cancel;
		shd_d = snp_read;
		if (snp_cancel)
			rv_d = 1'b0;
		if (sc_take) begin
			ok_d = rv_q && !snp_cancel &&
				(sc_addr_in[`RSF_ADDR_W-1:`RSF_BLK_LSB] == ra_q[`RSF_ADDR_W-1:`RSF_BLK_LSB]);
			rv_d = 1'b0;
		end
		// a new reservation beats a cancel aimed at the old one
		if (lr_take && lr_cacheable_in && lr_cache_hit_in) begin
			rv_d = 1'b1;
			ra_d = lr_addr_in;
		end
		// snooping must start at the acknowledge, before data returns
		if (ack_ra) begin
			rv_d = 1'b1;
			ra_d = addr_q;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			rv_q  <= 1'b0;
			ra_q  <= `RSF_ADDR_RST;
			ok_q  <= 1'b0;
			cx_q  <= 1'b0;
			shd_q <= 1'b0;
		end else if (ce_in) begin
			rv_q  <= rv_d;
			ra_q  <= ra_d;
			ok_q  <= ok_d;
			cx_q  <= cx_d;
			shd_q <= shd_d;
		end
	end

	// ==========================================================
	// outputs
	assign bus.reservation_held = rv_q;
	assign bus.shared_response  = shd_q;
	assign resv_valid_out       = rv_q;
	assign resv_addr_out        = ra_q;
	assign sc_success_out       = ok_q;
	assign resv_cancel_out      = cx_q;
endmodule
